// ===== sfm_fifo.sv
// single-clock 36-bit fifo with port b bus sizing, mailboxes and retransmit
//
// Operation
// R01: almost-full flag deasserts the cycle after a freeing read.
// R02: in word or byte size, the last sub-word read counts as the read.
// R03: port a writes with select low, direction high, mail select low.
// R04: port b reads with select low, direction high, mail select low.
// R05: almost-full is judged against the built depth of 2,048, 4,096 or 8,192.
// R06: word size: forward mail takes low 18 port a lines, shows on low 18 b.
// R07: byte size: forward mail takes low nine port a lines, shows on low nine b.
// R08: word size: reverse mail takes low 18 port b lines, shows on low 18 a.
// R09: byte size: reverse mail takes low nine port b lines, shows on low nine a.
// R10: reader waits for the empty flag to rise after retransmit setup.
// R11: retransmit replays from the first word written after reset.
// R12: writer stores at most depth minus two words before retransmit setup.
// R13: depth chains tie both mail selects low and skip mailboxes.
// R14: chain transfer clock is the faster of the two port clocks.
// R15: chain fall-through is (N-1) times four transfers plus three read clocks.
// R16: chain full recovery is (N-1) times three transfers plus two write clocks.
// R17: unused upper port b lines carry no valid data in narrow sizes.
// R18: retransmit rewinds the read pointer, drops empty, raises it when set up.
`timescale 1ns/10ps
module sfm_fifo
  import sfm_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // static configuration
  input wire logic [1:0] busSize,
  input wire logic bigEndian,
  // port a strobes and data
  input wire logic writePortSelectN,
  input wire logic writePortDirection,
  input wire logic writePortMailSelect,
  input wire logic [DATA_W-1:0] dataAIn,
  output logic [DATA_W-1:0] dataAOut,
  output logic dataAOe,
  // port b strobes and data
  input wire logic readPortSelectN,
  input wire logic readPortDirection,
  input wire logic readPortMailSelect,
  input wire logic [DATA_W-1:0] dataBIn,
  output logic [DATA_W-1:0] dataBOut,
  output logic dataBOe,
  // retransmit request, one cycle
  input wire logic retransmit,
  // flags
  output logic full_n,
  output logic almost_full_n,
  output logic empty_n,
  output logic fwd_mail_full_n,
  output logic rev_mail_full_n
);

  logic [DATA_W-1:0] mem [DEPTH];
  logic [ADDR_W-1:0] wrPtr;
  logic [ADDR_W-1:0] rdPtr;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic [CNT_W-1:0] writtenSinceReset;
  logic [1:0] subIdx;
  logic [1:0] setupLeft;
  logic fifoWrite;
  logic fifoRead;
  logic lastSub;
  logic mailAWrite;
  logic mailARead;
  logic mailBWrite;
  logic mailBRead;
  logic [DATA_W-1:0] sizeMask;

  sfm_mail_if mailBus ();

  // valid-line mask for the current port b size
  function automatic logic [DATA_W-1:0] laneMask(input logic [1:0] size);
    unique case (size)
      SIZE_WORD: laneMask = MASK_WORD;
      SIZE_BYTE: laneMask = MASK_BYTE;
      default: laneMask = MASK_LONG;
    endcase
  endfunction : laneMask

  // pick the sub-word of a long word for a narrow read, in endian order
  function automatic logic [DATA_W-1:0] pickSub(input logic [DATA_W-1:0] word, input logic [1:0] size,
                                                input logic big, input logic [1:0] idx);
    logic [1:0] lane;
    lane = 2'h0;
    pickSub = word;
    unique case (size)
      SIZE_WORD: begin
        lane = (big ^ idx[0]) ? 2'h2 : 2'h0; // upper half first when big
        pickSub = {18'h0_0000, word[lane*LANE_W +: 2*LANE_W]};
      end
      SIZE_BYTE: begin
        lane = big ? 2'(2'h3 - idx) : idx;
        pickSub = {27'h000_0000, word[lane*LANE_W +: LANE_W]};
      end
      default: pickSub = word;
    endcase
  endfunction : pickSub

  // strobe decode; mailbox traffic never touches the array
  assign fifoWrite = !writePortSelectN && writePortDirection && !writePortMailSelect && full_n; // [R03]
  assign fifoRead = !readPortSelectN && readPortDirection && !readPortMailSelect && empty_n; // [R04] [R10]
  assign mailAWrite = !writePortSelectN && writePortDirection && writePortMailSelect;
  assign mailARead = !writePortSelectN && !writePortDirection && writePortMailSelect;
  assign mailBWrite = !readPortSelectN && !readPortDirection && readPortMailSelect;
  assign mailBRead = !readPortSelectN && readPortDirection && readPortMailSelect;
  assign sizeMask = laneMask(busSize);

  // a long word is freed only by its final sub-word
  assign lastSub = (busSize == SIZE_LONG) || (busSize == SIZE_WORD && subIdx == 2'h1) ||
                   (busSize == SIZE_BYTE && subIdx == 2'h3); // [R02]

  // occupancy; retransmit restores everything written since reset
  always_comb begin
    next_count = count;
    if (retransmit) begin
      next_count = writtenSinceReset + CNT_W'(fifoWrite); // [R11]
    end else if (fifoWrite && !(fifoRead && lastSub)) begin
      next_count = count + 12'h001;
    end else if (!fifoWrite && fifoRead && lastSub) begin
      next_count = count - 12'h001;
    end
  end

  // array write and write pointer
  always_ff @(posedge clock) begin
    if (fifoWrite) begin
      mem[wrPtr] <= dataAIn;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr <= '0;
    end else if (fifoWrite) begin
      wrPtr <= wrPtr + 11'h001;
    end
  end

  // words written since reset; saturates so a wrapped ring cannot alias
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      writtenSinceReset <= '0;
    end else if (fifoWrite && writtenSinceReset != DEPTH_CNT) begin
      writtenSinceReset <= writtenSinceReset + 12'h001;
    end
  end

  // read pointer and sub-word index
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdPtr <= '0;
      subIdx <= 2'h0;
    end else if (retransmit) begin
      rdPtr <= '0; // first word after reset sits at address zero [R18] [R11]
      subIdx <= 2'h0;
    end else if (fifoRead) begin
      subIdx <= lastSub ? 2'h0 : subIdx + 2'h1;
      if (lastSub) begin
        rdPtr <= rdPtr + 11'h001;
      end
    end
  end

  // occupancy register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  // retransmit setup countdown holds the empty flag low
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      setupLeft <= 2'h0;
    end else if (retransmit) begin
      setupLeft <= RT_SETUP_CYCLES; // [R18]
    end else if (setupLeft != 2'h0) begin
      setupLeft <= setupLeft - 2'h1;
    end
  end

  // flags from the next occupancy so a freeing read shows one edge later
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      full_n <= 1'b1;
      almost_full_n <= 1'b1;
      empty_n <= 1'b0;
    end else begin
      full_n <= next_count < DEPTH_CNT; // one edge after a freeing read [R16]
      almost_full_n <= next_count < NEAR_FULL_LEVEL; // [R01] [R05]
      empty_n <= next_count != '0 && !retransmit && (setupLeft <= 2'h1); // [R18] [R10] [R15]
    end
  end

  // port b output register: fifo data or forward mail, narrow sizes zero-fill
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dataBOut <= DATA_RST;
      dataBOe <= 1'b0;
    end else begin
      dataBOe <= !readPortSelectN && readPortDirection;
      if (fifoRead) begin
        dataBOut <= pickSub(mem[rdPtr], busSize, bigEndian, subIdx); // [R17]
      end else if (mailBRead) begin
        dataBOut <= mailBus.fwdOut & sizeMask; // [R06] [R07]
      end
    end
  end

  // port a output register: reverse mail only
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dataAOut <= DATA_RST;
      dataAOe <= 1'b0;
    end else begin
      dataAOe <= !writePortSelectN && !writePortDirection;
      if (mailARead) begin
        dataAOut <= mailBus.revOut & sizeMask; // [R08] [R09]
      end
    end
  end

  // mailbox strobes and captured lines, masked to the port b width
  assign mailBus.fwdWrite = mailAWrite;
  assign mailBus.fwdRead = mailBRead;
  assign mailBus.revWrite = mailBWrite;
  assign mailBus.revRead = mailARead;
  assign mailBus.fwdIn = dataAIn & sizeMask; // upper port a lines ignored [R06] [R07]
  assign mailBus.revIn = dataBIn & sizeMask; // [R08] [R09]
  assign fwd_mail_full_n = mailBus.fwdFullN;
  assign rev_mail_full_n = mailBus.revFullN;

  sfm_mailbox mailboxes (
    .clock(clock),
    .rst_n(rst_n),
    .mail(mailBus.box)
  );

endmodule : sfm_fifo

// ===== sfm_pkg.sv
// shared constants for the single-clock fifo with mailboxes and retransmit
package sfm_pkg;
  // capacity variant being built: 2,048, 4,096 or 8,192 long words
  localparam int DEPTH = 2048;
  localparam int ADDR_W = $clog2(DEPTH);
  localparam int CNT_W = ADDR_W + 1;
  localparam int DATA_W = 36;
  localparam int LANE_W = 9;
  // almost-full offset, counted in free long words
  localparam logic [CNT_W-1:0] NEAR_FULL_OFFSET = 12'h0008;
  localparam logic [CNT_W-1:0] DEPTH_CNT = CNT_W'(DEPTH);
  localparam logic [CNT_W-1:0] NEAR_FULL_LEVEL = DEPTH_CNT - NEAR_FULL_OFFSET;
  // port b bus size encodings
  localparam logic [1:0] SIZE_LONG = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_BYTE = 2'h2;
  // cycles that the empty flag stays low during retransmit setup
  localparam logic [1:0] RT_SETUP_CYCLES = 2'h3;
  // reset values
  localparam logic [DATA_W-1:0] DATA_RST = 36'h0_0000_0000;
  // valid-line masks per port b bus size
  localparam logic [DATA_W-1:0] MASK_WORD = 36'h0_0003_FFFF;
  localparam logic [DATA_W-1:0] MASK_BYTE = 36'h0_0000_01FF;
  localparam logic [DATA_W-1:0] MASK_LONG = 36'hF_FFFF_FFFF;
endpackage : sfm_pkg

// ===== sfm_mail_if.sv
// carrier between the fifo core and the mailbox pair
`timescale 1ns/10ps
interface sfm_mail_if;
  import sfm_pkg::*;
  logic fwdWrite;
  logic fwdRead;
  logic revWrite;
  logic revRead;
  logic [DATA_W-1:0] fwdIn;
  logic [DATA_W-1:0] revIn;
  logic [DATA_W-1:0] fwdOut;
  logic [DATA_W-1:0] revOut;
  logic fwdFullN;
  logic revFullN;
  modport core (output fwdWrite, fwdRead, revWrite, revRead, fwdIn, revIn,
                input fwdOut, revOut, fwdFullN, revFullN);
  modport box (input fwdWrite, fwdRead, revWrite, revRead, fwdIn, revIn,
               output fwdOut, revOut, fwdFullN, revFullN);
endinterface : sfm_mail_if

// ===== sfm_mailbox.sv
// two bypass mailbox registers with their full flags
`timescale 1ns/10ps
module sfm_mailbox
  import sfm_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // core side
  sfm_mail_if.box mail
);

  // forward mailbox data, port a to port b
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mail.fwdOut <= DATA_RST;
    end else if (mail.fwdWrite) begin
      mail.fwdOut <= mail.fwdIn; // lane masking done by the core [R06] [R07]
    end
  end

  // forward flag: a new letter beats a read in the same cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mail.fwdFullN <= 1'b1;
    end else if (mail.fwdWrite) begin
      mail.fwdFullN <= 1'b0;
    end else if (mail.fwdRead) begin
      mail.fwdFullN <= 1'b1;
    end
  end

  // reverse mailbox data, port b to port a
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mail.revOut <= DATA_RST;
    end else if (mail.revWrite) begin
      mail.revOut <= mail.revIn; // [R08] [R09]
    end
  end

  // reverse flag, same set-wins policy
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mail.revFullN <= 1'b1;
    end else if (mail.revWrite) begin
      mail.revFullN <= 1'b0;
    end else if (mail.revRead) begin
      mail.revFullN <= 1'b1;
    end
  end

endmodule : sfm_mailbox

// ===== sfm_fifo_assertions.sv
// concurrent checks on the fifo top-level ports
`timescale 1ns/10ps
module sfm_fifo_checker
  import sfm_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // configuration and strobes
  input wire logic [1:0] busSize,
  input wire logic writePortSelectN,
  input wire logic writePortDirection,
  input wire logic writePortMailSelect,
  input wire logic readPortSelectN,
  input wire logic readPortDirection,
  input wire logic readPortMailSelect,
  input wire logic retransmit,
  // data and flags
  input wire logic [DATA_W-1:0] dataAOut,
  input wire logic [DATA_W-1:0] dataBOut,
  input wire logic almost_full_n,
  input wire logic empty_n,
  input wire logic fwd_mail_full_n,
  input wire logic rev_mail_full_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // strobes decoded once so the size and almost-full properties read the same cause; the mail flag properties decode their own
  logic aRev;
  logic bRead;
  logic bFifo;
  assign aRev = !writePortSelectN && !writePortDirection && writePortMailSelect;
  assign bRead = !readPortSelectN && readPortDirection;
  assign bFifo = bRead && !readPortMailSelect;
  word_b_upper_a: assert property (bRead && busSize == SIZE_WORD |=> dataBOut[35:18] == 18'h0_0000)
    else $error("port b upper lines driven in word size");
  byte_b_upper_a: assert property (bRead && busSize == SIZE_BYTE |=> dataBOut[35:9] == 27'h000_0000)
    else $error("port b upper lines driven in byte size");
  word_a_upper_a: assert property (aRev && busSize == SIZE_WORD |=> dataAOut[35:18] == 18'h0_0000)
    else $error("port a upper lines driven in word size");
  byte_a_upper_a: assert property (aRev && busSize == SIZE_BYTE |=> dataAOut[35:9] == 27'h000_0000)
    else $error("port a upper lines driven in byte size");
  fwd_mail_flag_a: assert property (!writePortSelectN && writePortDirection && writePortMailSelect
    |=> !fwd_mail_full_n)
    else $error("forward mail flag did not fall");
  rev_mail_flag_a: assert property (!readPortSelectN && !readPortDirection && readPortMailSelect
    |=> !rev_mail_full_n)
    else $error("reverse mail flag did not fall");
  rewind_empty_a: assert property (retransmit |=> !empty_n [*2])
    else $error("empty flag not low during rewind");
  near_full_release_a: assert property ($rose(almost_full_n) |-> $past(bFifo))
    else $error("almost-full released without a read");
endmodule : sfm_fifo_checker

bind sfm_fifo sfm_fifo_checker u_sfm_fifo_checker (.clock, .rst_n, .busSize, .writePortSelectN, .writePortDirection,
  .writePortMailSelect, .readPortSelectN, .readPortDirection, .readPortMailSelect, .retransmit, .dataAOut,
  .dataBOut, .almost_full_n, .empty_n, .fwd_mail_full_n, .rev_mail_full_n);

// ===== sfm_port_b_model.sv
// port b party: turns an operation code into strobes and bus data
`timescale 1ns/10ps
module sfm_port_b_model
  import sfm_pkg::*;
(
  // clock
  input wire logic clock,
  // request: 0 idle, 1 fifo read, 2 forward mail read, 3 reverse mail write
  input wire logic [1:0] op,
  input wire logic [DATA_W-1:0] wdata,
  // port b pins
  output logic selN,
  output logic dir,
  output logic mail,
  output logic [DATA_W-1:0] bus
);
  logic [DATA_W-1:0] last = DATA_RST;
  // strobes follow the request, held until the next edge
  assign selN = (op == 2'h0);
  assign dir = (op != 2'h3);
  assign mail = op[1];
  // released bus shows no stale copy, so a lazy capture cannot pass by luck
  assign bus = (op == 2'h3) ? wdata : ~last;
  always @(posedge clock) begin
    last <= bus;
  end
endmodule : sfm_port_b_model

// ===== sfm_fifo_bench.sv
// self-checking bench for the fifo with mailboxes and retransmit
`timescale 1ns/10ps
module sfm_fifo_bench;
  import sfm_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] busSize = SIZE_LONG;
  logic bigEndian = 1'b1;
  logic aSelN = 1'b1;
  logic aDir = 1'b1;
  logic aMail = 1'b0;
  logic [DATA_W-1:0] dataAIn = DATA_RST;
  logic [1:0] bOp = 2'h0;
  logic [DATA_W-1:0] bData = DATA_RST;
  logic retransmit = 1'b0;
  logic bSelN, bDir, bMail, almost_full_n, empty_n, full_n, fwd_mail_full_n, rev_mail_full_n;
  logic dataAOe, dataBOe, bigSel;
  int sizeSel;
  logic [DATA_W-1:0] dataBIn, dataAOut, dataBOut, w, m;
  int errors = 0;
  int samplesChecked = 0;

  sfm_fifo u_sfm_fifo (.clock, .rst_n, .busSize, .bigEndian, .writePortSelectN(aSelN), .writePortDirection(aDir),
    .writePortMailSelect(aMail), .dataAIn, .dataAOut, .dataAOe, .readPortSelectN(bSelN), .readPortDirection(bDir),
    .readPortMailSelect(bMail), .dataBIn, .dataBOut, .dataBOe, .retransmit, .full_n, .almost_full_n, .empty_n,
    .fwd_mail_full_n, .rev_mail_full_n);
  sfm_port_b_model u_sfm_port_b_model (.clock, .op(bOp), .wdata(bData), .selN(bSelN), .dir(bDir), .mail(bMail),
    .bus(dataBIn));

  // 25 mhz clock
  initial begin
    forever #20 clock = ~clock; // one clock serves both ports, so it is also the faster one
  end

  // one cycle of both ports: 0 idle, 1 fifo, 2 forward mail, 3 reverse mail
  task automatic cyc(input logic [1:0] a, input logic [1:0] b, input logic [DATA_W-1:0] d);
    aSelN <= (a == 2'h0);
    aDir <= (a != 2'h3);
    aMail <= a[1]; // stays low on array traffic, as a chained part needs
    dataAIn <= (a == 2'h0) ? ~dataAIn : d;
    bOp <= b;
    bData <= d;
    @(posedge clock);
    #1;
  endtask : cyc

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // size and endianness are static, so they only change under reset
  task automatic rst(input logic [1:0] sz, input logic be);
    rst_n <= 1'b0;
    busSize <= sz;
    bigEndian <= be;
    repeat (10) @(posedge clock);
    #1;
    rst_n <= 1'b1;
  endtask : rst

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", samplesChecked, errors);
    if (errors == 0 && samplesChecked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    rst(SIZE_LONG, 1'b1);
    // fill to the almost-full level, still short of the limit before a rewind
    for (int i = 0; i < int'(NEAR_FULL_LEVEL); i++) begin
      if (i == int'(NEAR_FULL_LEVEL) - 1) begin
        chk(36'(almost_full_n), 36'h1);
      end
      cyc(2'h1, 2'h0, 36'hA_0000_0000 + 36'(i));
    end
    chk(36'(almost_full_n), 36'h0);
    chk(36'(full_n), 36'h1);
    cyc(2'h0, 2'h1, DATA_RST);
    chk(dataBOut, 36'hA_0000_0000);
    chk(36'(almost_full_n), 36'h1);
    retransmit <= 1'b1;
    cyc(2'h0, 2'h0, DATA_RST);
    retransmit <= 1'b0;
    chk(36'(empty_n), 36'h0);
    // reader holds off until setup ends, bounded
    for (int k = 0; k < 8 && empty_n !== 1'b1; k++) begin
      cyc(2'h0, 2'h0, DATA_RST);
    end
    if (empty_n !== 1'b1) begin
      errors++;
      report_and_stop();
    end
    for (int j = 0; j < 2; j++) begin
      cyc(2'h0, 2'h1, DATA_RST);
      chk(dataBOut, 36'hA_0000_0000 + 36'(j));
    end
    // top up past the limit; one read must free a slot by the next edge
    for (int j = 0; j < 11; j++) begin
      cyc(2'h1, 2'h0, 36'hB_0000_0000 + 36'(j));
    end
    chk(36'(full_n), 36'h0);
    cyc(2'h0, 2'h1, DATA_RST);
    chk(dataBOut, 36'hA_0000_0002);
    chk(36'(full_n), 36'h1);
    // word and byte size, each in both endian orders
    for (int k = 0; k < 4; k++) begin
      sizeSel = 1 + k % 2;
      bigSel = (k < 2) == (sizeSel == 1);
      rst(2'(sizeSel), bigSel);
      m = (sizeSel == 1) ? 36'h0_0003_FFFF : 36'h0_0000_01FF;
      w = 36'h9_8765_4321;
      cyc(2'h1, 2'h0, w);
      chk(36'(empty_n), 36'h1);
      for (int j = 0; j < 2 * sizeSel; j++) begin
        cyc(2'h0, 2'h1, DATA_RST);
        chk(dataBOut, (w >> ((bigSel ? 2 * sizeSel - 1 - j : j) * 18 / sizeSel)) & m);
      end
      chk(36'(empty_n), 36'h0);
      // mail data with live upper lines, so a missing mask shows
      cyc(2'h2, 2'h0, w);
      chk(36'(fwd_mail_full_n), 36'h0);
      cyc(2'h0, 2'h2, DATA_RST);
      chk(dataBOut, w & m);
      chk(36'(fwd_mail_full_n), 36'h1);
      chk(36'(dataBOe), 36'h1);
      cyc(2'h0, 2'h3, ~w);
      chk(36'(rev_mail_full_n), 36'h0);
      cyc(2'h3, 2'h0, DATA_RST);
      chk(dataAOut, ~w & m);
      chk(36'(rev_mail_full_n), 36'h1);
      chk(36'(dataAOe), 36'h1);
    end
    report_and_stop();
  end
endmodule : sfm_fifo_bench
